// >>> src/pdc_ctrl.sv
// stop/idle power-down controller with apb register access
//
// Local design decisions: register access over APB and the register offsets.
module pdc_ctrl (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic CPU_EXEC,
  input wire logic [7:0] CPU_OPCODE,
  input wire logic EXTERNAL_RESET_PIN_N,
  input wire logic [7:0] PORT0_WAKE_IRQS,
  input wire logic [7:0] PORT0_WAKE_EN,
  input wire logic IRQ_PENDING,
  output logic CPU_CLK_EN,
  output logic PERIPH_CLK_EN,
  output logic OSC_EN,
  output logic [1:0] CLK_SEL,
  output logic CTRL_RST_N,
  output logic REGFILE_HOLD,
  output logic PORT_HOLD,
  output logic CPU_START,
  output logic [15:0] START_ADDR,
  output logic WAKE_SERVICE
);
  import pdc_pkg::*;

  pdc_state_t state;
  pdc_state_t next_state;

  logic rst_pin_a;
  logic rst_pin_b;
  logic ext_rst;
  logic [7:0] p0_filt;
  logic [7:0] p0_prev;
  logic p0_wake;
  logic any_irq;
  logic stab_start;
  logic stab_done;
  logic enter_stop;
  logic enter_idle;
  logic osc_stop_wr;
  logic leave_by_irq;

  logic [7:0] clock_select_reg;
  logic [7:0] stop_enable_reg;
  logic [7:0] oscillator_control_reg;
  logic [7:0] stab_count_reg;
  logic wake_irq_flag;
  logic wake_rst_flag;

  logic wr_en;
  logic rd_en;
  logic [31:0] next_prdata;

  function automatic logic hit(input logic [11:0] addr, input logic [11:0] ofs);
    hit = (addr == ofs);
  endfunction

  function automatic logic mapped(input logic [11:0] addr);
    mapped = hit(addr, OFS_CLOCK_SELECT) || hit(addr, OFS_STOP_ENABLE) ||
             hit(addr, OFS_OSC_CONTROL) || hit(addr, OFS_STAB_COUNT) ||
             hit(addr, OFS_STATUS);
  endfunction

  // reset pin is asynchronous to the core clock
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rst_pin_a <= 1'b0;
      rst_pin_b <= 1'b0;
    end else begin
      rst_pin_a <= EXTERNAL_RESET_PIN_N;
      rst_pin_b <= rst_pin_a;
    end
  end
  assign ext_rst = !rst_pin_b;

  pdc_noise_filter u_filter (
    .CLK(CLK),
    .RST_N(RST_N),
    .PIN_IN(PORT0_WAKE_IRQS),
    .PIN_OUT(p0_filt)
  );

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      p0_prev <= 8'h00;
    end else begin
      p0_prev <= p0_filt;
    end
  end
  // either edge on an enabled, filtered port 0 line
  assign p0_wake = |((p0_filt ^ p0_prev) & PORT0_WAKE_EN);
  assign any_irq = p0_wake || IRQ_PENDING;

  // zero wait state slave; unmapped addresses error out
  assign PREADY = 1'b1;
  assign wr_en = PSEL && PENABLE && PWRITE;
  // read word is captured in the setup cycle and stands through the access phase
  assign rd_en = PSEL && !PENABLE && !PWRITE;
  assign PSLVERR = PSEL && PENABLE && !mapped(PADDR);

  assign osc_stop_wr = wr_en && hit(PADDR, OFS_OSC_CONTROL) && PWDATA[OSC_STOP_BIT];
  // stop opcode only takes effect once software has armed it
  assign enter_stop = (CPU_EXEC && CPU_OPCODE == OP_STOP &&
                       stop_enable_reg[STOP_ARM_BIT]) || osc_stop_wr;
  assign enter_idle = CPU_EXEC && CPU_OPCODE == OP_IDLE;

  always_comb begin
    next_state = state;
    case (state)
      PDC_RUN: begin
        if (ext_rst) begin
          next_state = PDC_RST_HOLD;
        end else if (enter_stop) begin
          next_state = PDC_STOP;
        end else if (enter_idle) begin
          next_state = PDC_IDLE;
        end
      end
      PDC_IDLE: begin
        // reset checked first so it wins a tie
        if (ext_rst) begin
          next_state = PDC_RST_HOLD;
        end else if (any_irq) begin
          next_state = PDC_RUN;
        end
      end
      PDC_STOP: begin
        if (ext_rst) begin
          next_state = PDC_RST_HOLD;
        end else if (any_irq) begin
          next_state = PDC_STAB_IRQ;
        end
      end
      PDC_STAB_IRQ: begin
        if (ext_rst) begin
          next_state = PDC_RST_HOLD;
        end else if (stab_done) begin
          next_state = PDC_RUN;
        end
      end
      PDC_RST_HOLD: begin
        if (!ext_rst) begin
          next_state = PDC_STAB_RST;
        end
      end
      PDC_STAB_RST: begin
        if (ext_rst) begin
          next_state = PDC_RST_HOLD;
        end else if (stab_done) begin
          next_state = PDC_RUN;
        end
      end
      default: next_state = PDC_RST_HOLD;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state <= PDC_RST_HOLD;
    end else begin
      state <= next_state;
    end
  end

  // timer loads from the register; after a reset it holds its default
  assign stab_start = (next_state == PDC_STAB_IRQ && state != PDC_STAB_IRQ) ||
                      (next_state == PDC_STAB_RST && state != PDC_STAB_RST);
  assign leave_by_irq = (state == PDC_STAB_IRQ || state == PDC_IDLE) &&
                        next_state == PDC_RUN;

  pdc_stab_timer u_stab (
    .CLK(CLK),
    .RST_N(RST_N),
    .START(stab_start),
    .COUNT(stab_count_reg),
    .DONE(stab_done)
  );

  // control registers: defaults on either reset, kept on interrupt wake except the oscillator stop bit, which clears on a wake from stop
  always_ff @(posedge CLK) begin
    if (!RST_N || ext_rst) begin
      clock_select_reg <= CLOCK_SELECT_RST;
      oscillator_control_reg <= OSC_CONTROL_RST;
      stab_count_reg <= STAB_COUNT_RST;
    end else begin
      if (wr_en && hit(PADDR, OFS_CLOCK_SELECT)) begin
        clock_select_reg <= PWDATA[7:0];
      end
      if (wr_en && hit(PADDR, OFS_STAB_COUNT)) begin
        stab_count_reg <= PWDATA[7:0];
      end
      if (wr_en && hit(PADDR, OFS_OSC_CONTROL)) begin
        oscillator_control_reg <= PWDATA[7:0];
      end else if (state == PDC_STOP && next_state == PDC_STAB_IRQ) begin
        oscillator_control_reg[OSC_STOP_BIT] <= 1'b0;
      end
    end
  end

  // stop enable is the one control register cleared whole by an interrupt wake from stop
  always_ff @(posedge CLK) begin
    if (!RST_N || ext_rst) begin
      stop_enable_reg <= STOP_ENABLE_RST;
    end else if (wr_en && hit(PADDR, OFS_STOP_ENABLE)) begin
      stop_enable_reg <= PWDATA[7:0];
    end else if (state == PDC_STOP && next_state == PDC_STAB_IRQ) begin
      stop_enable_reg <= STOP_ENABLE_RST;
    end
  end

  // last wake cause, for software to inspect
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      wake_irq_flag <= 1'b0;
      wake_rst_flag <= 1'b0;
    end else if (state == PDC_STAB_RST && next_state == PDC_RUN) begin
      wake_irq_flag <= 1'b0;
      wake_rst_flag <= 1'b1;
    end else if (leave_by_irq) begin
      wake_irq_flag <= 1'b1;
      wake_rst_flag <= 1'b0;
    end
  end

  always_comb begin
    next_prdata = 32'h0000_0000;
    case (1'b1)
      hit(PADDR, OFS_CLOCK_SELECT): next_prdata[7:0] = clock_select_reg;
      hit(PADDR, OFS_STOP_ENABLE): next_prdata[7:0] = stop_enable_reg;
      hit(PADDR, OFS_OSC_CONTROL): next_prdata[7:0] = oscillator_control_reg;
      hit(PADDR, OFS_STAB_COUNT): next_prdata[7:0] = stab_count_reg;
      hit(PADDR, OFS_STATUS): begin
        next_prdata[5:0] = state;
        next_prdata[ST_WAKE_IRQ_BIT] = wake_irq_flag;
        next_prdata[ST_WAKE_RST_BIT] = wake_rst_flag;
      end
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  // registered so the read word cannot ripple during the access phase
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      PRDATA <= 32'h0000_0000;
    end else if (rd_en) begin
      PRDATA <= next_prdata;
    end
  end

  // clock gating follows the mode the controller is moving into
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      CPU_CLK_EN <= 1'b0;
      PERIPH_CLK_EN <= 1'b0;
      OSC_EN <= 1'b1;
      REGFILE_HOLD <= 1'b0;
      PORT_HOLD <= 1'b0;
      CTRL_RST_N <= 1'b0;
    end else begin
      CPU_CLK_EN <= next_state == PDC_RUN;
      PERIPH_CLK_EN <= next_state == PDC_RUN || next_state == PDC_IDLE;
      OSC_EN <= next_state != PDC_STOP;
      REGFILE_HOLD <= next_state == PDC_STOP;
      PORT_HOLD <= next_state == PDC_IDLE;
      CTRL_RST_N <= next_state != PDC_RST_HOLD;
    end
  end

  // interrupt wake leaves clock select as programmed
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      CLK_SEL <= 2'b00;
    end else begin
      CLK_SEL <= clock_select_reg[CLKSEL_HI:CLKSEL_LO];
    end
  end

  // cpu resumes via vector fetch after reset, or via service after wake
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      CPU_START <= 1'b0;
      START_ADDR <= 16'h0000;
      WAKE_SERVICE <= 1'b0;
    end else begin
      CPU_START <= state == PDC_STAB_RST && next_state == PDC_RUN;
      START_ADDR <= RESET_VECTOR;
      WAKE_SERVICE <= leave_by_irq;
    end
  end
endmodule

// >>> src/pdc_noise_filter.sv
// port 0 wake input synchroniser and glitch filter
module pdc_noise_filter (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [7:0] PIN_IN,
  output logic [7:0] PIN_OUT
);
  import pdc_pkg::*;

  logic [7:0] sync_a;
  logic [7:0] sync_b;

  // the first stage feeds only the second
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sync_a <= 8'h00;
      sync_b <= 8'h00;
    end else begin
      sync_a <= PIN_IN;
      sync_b <= sync_a;
    end
  end

  for (genvar i = 0; i < 8; i++) begin : g_bit
    logic [FILT_W-1:0] cnt;
    always_ff @(posedge CLK) begin
      if (!RST_N) begin
        cnt <= '0;
        PIN_OUT[i] <= 1'b0;
      end else if (sync_b[i] == PIN_OUT[i]) begin
        cnt <= '0;
      end else if (cnt == FILT_W'(FILT_CYCLES - 1)) begin
        cnt <= '0;
        PIN_OUT[i] <= sync_b[i];
      end else begin
        cnt <= cnt + FILT_W'(1);
      end
    end
  end
endmodule

// >>> src/pdc_pkg.sv
// shared constants for the stop/idle power-down controller
package pdc_pkg;
  localparam int unsigned CLK_MHZ = 125;

  localparam logic [7:0] OP_STOP = 8'h7f;
  localparam logic [7:0] OP_IDLE = 8'h6f;

  localparam logic [15:0] RESET_VECTOR = 16'h0100;

  localparam logic [11:0] OFS_CLOCK_SELECT = 12'h000;
  localparam logic [11:0] OFS_STOP_ENABLE = 12'h004;
  localparam logic [11:0] OFS_OSC_CONTROL = 12'h008;
  localparam logic [11:0] OFS_STAB_COUNT = 12'h00c;
  localparam logic [11:0] OFS_STATUS = 12'h010;

  localparam int unsigned CLKSEL_LO = 3;
  localparam int unsigned CLKSEL_HI = 4;
  localparam int unsigned STOP_ARM_BIT = 0;
  localparam int unsigned OSC_STOP_BIT = 2;
  localparam int unsigned ST_WAKE_IRQ_BIT = 8;
  localparam int unsigned ST_WAKE_RST_BIT = 9;

  localparam logic [7:0] CLOCK_SELECT_RST = 8'h00;
  localparam logic [7:0] STOP_ENABLE_RST = 8'h00;
  localparam logic [7:0] OSC_CONTROL_RST = 8'h00;
  localparam logic [7:0] STAB_COUNT_RST = 8'hff;

  // port 0 noise filter: a level must hold this many cycles to pass
  localparam int unsigned FILT_CYCLES = 4;
  localparam int unsigned FILT_W = 3;

  typedef enum logic [5:0] {
    PDC_RUN      = 6'b000001,
    PDC_IDLE     = 6'b000010,
    PDC_STOP     = 6'b000100,
    PDC_STAB_IRQ = 6'b001000,
    PDC_RST_HOLD = 6'b010000,
    PDC_STAB_RST = 6'b100000
  } pdc_state_t;
endpackage

// >>> src/pdc_stab_timer.sv
// oscillation stabilization wait counter
module pdc_stab_timer (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic START,
  input wire logic [7:0] COUNT,
  output logic DONE
);
  import pdc_pkg::*;

  logic [11:0] remain;
  logic busy;

  // wait is (COUNT+1)*16 cycles, loaded without arithmetic
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      remain <= 12'h000;
      busy <= 1'b0;
      DONE <= 1'b0;
    end else begin
      DONE <= 1'b0;
      if (START) begin
        remain <= {COUNT, 4'hf};
        busy <= 1'b1;
      end else if (busy) begin
        if (remain == 12'h000) begin
          busy <= 1'b0;
          DONE <= 1'b1;
        end else begin
          remain <= remain - 12'h001;
        end
      end
    end
  end
endmodule

// >>> verif/pdc_cpu_model.sv
// cpu core stand-in: issues opcodes and holds an interrupt request
module pdc_cpu_model (
  input wire logic clk,
  input wire logic wake_service,
  input wire logic ctrl_rst_n,
  output logic cpu_exec,
  output logic [7:0] cpu_opcode,
  output logic irq_pending
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cpu_exec = 1'b0;
    cpu_opcode = 8'h00;
    irq_pending = 1'b0;
  end
  task exec(input logic [7:0] op);
    cpu_opcode <= op;
    cpu_exec <= 1'b1;
    @(posedge clk);
    cpu_exec <= 1'b0;
    @(posedge clk);
  endtask
  task irq();
    irq_pending <= 1'b1;
  endtask
  // level stays until the core takes the service pulse; reset drops it
  always @(posedge clk) begin
    if (wake_service || !ctrl_rst_n) begin
      irq_pending <= 1'b0;
    end
  end
endmodule

// >>> verif/pdc_ctrl_sva.sv
// assertion checker for the power-down controller ports
module pdc_ctrl_sva
  import pdc_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic CPU_EXEC,
  input wire logic [7:0] CPU_OPCODE,
  input wire logic IRQ_PENDING,
  input wire logic EXTERNAL_RESET_PIN_N,
  input wire logic CPU_CLK_EN,
  input wire logic PERIPH_CLK_EN,
  input wire logic OSC_EN,
  input wire logic [1:0] CLK_SEL,
  input wire logic CTRL_RST_N,
  input wire logic REGFILE_HOLD,
  input wire logic PORT_HOLD,
  input wire logic CPU_START,
  input wire logic [15:0] START_ADDR,
  input wire logic WAKE_SERVICE
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  // either stop cause: opcode or any apb write (oscillator register)
  logic go_stop;
  assign go_stop = (CPU_EXEC && CPU_OPCODE == OP_STOP) || (PSEL && PENABLE && PWRITE);
  property p_idle_entry;
    CPU_EXEC && CPU_OPCODE == OP_IDLE && CPU_CLK_EN |=> !CPU_CLK_EN && PORT_HOLD && PERIPH_CLK_EN;
  endproperty
  a_idle_entry: assert property (p_idle_entry) else $error("idle entry wrong");
  property p_stop_frozen;
    !OSC_EN |-> !CPU_CLK_EN && !PERIPH_CLK_EN && REGFILE_HOLD;
  endproperty
  a_stop_frozen: assert property (p_stop_frozen) else $error("stop not frozen");
  property p_stop_cause;
    $fell(OSC_EN) |-> $past(go_stop);
  endproperty
  a_stop_cause: assert property (p_stop_cause) else $error("stop without cause");
  property p_idle_hold;
    PORT_HOLD |-> PERIPH_CLK_EN && !CPU_CLK_EN && OSC_EN;
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("idle clocks wrong");
  // the pin reaches the controller through two flip-flops
  property p_idle_wake;
    PORT_HOLD && IRQ_PENDING && $past(EXTERNAL_RESET_PIN_N, 2) |=>
      CPU_CLK_EN && WAKE_SERVICE && !PORT_HOLD;
  endproperty
  a_idle_wake: assert property (p_idle_wake) else $error("idle wake missing");
  property p_rst_first;
    PORT_HOLD && IRQ_PENDING && !$past(EXTERNAL_RESET_PIN_N, 2) |=> !CTRL_RST_N && !WAKE_SERVICE;
  endproperty
  a_rst_first: assert property (p_rst_first) else $error("wake beat reset");
  property p_stop_wake;
    !OSC_EN && IRQ_PENDING |=> OSC_EN;
  endproperty
  a_stop_wake: assert property (p_stop_wake) else $error("stop wake missing");
  property p_start_vec;
    CPU_START |-> START_ADDR == RESET_VECTOR && CLK_SEL == 2'b00;
  endproperty
  a_start_vec: assert property (p_start_vec) else $error("start vector wrong");
  property p_rst_slow;
    !CTRL_RST_N [*2] |-> CLK_SEL == 2'b00;
  endproperty
  a_rst_slow: assert property (p_rst_slow) else $error("reset clock not slow");
endmodule

bind pdc_ctrl pdc_ctrl_sva i_sva (.CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .CPU_EXEC,
  .CPU_OPCODE, .IRQ_PENDING, .EXTERNAL_RESET_PIN_N, .CPU_CLK_EN, .PERIPH_CLK_EN, .OSC_EN,
  .CLK_SEL, .CTRL_RST_N,
  .REGFILE_HOLD, .PORT_HOLD, .CPU_START, .START_ADDR, .WAKE_SERVICE);

// >>> verif/stop_idle_power_down_control_test.sv
// self-checking bench for the stop/idle power-down controller
module stop_idle_power_down_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  import pdc_pkg::*;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pin_n = 1, e;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic [7:0] p0 = '0, p0_en = '0, r = 8'h3f, opcode;
  logic pready, pslverr, cpu_exec, irq, cpu_clk_en, periph_clk_en, osc_en, ctrl_rst_n;
  logic regfile_hold, port_hold, cpu_start, wake;
  logic [1:0] clk_sel;
  logic [15:0] start_addr;
  int fails = 0, compares = 0, n, exp_sel;
  always #4 clk = ~clk;
  pdc_ctrl i_dut (
    .CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CPU_EXEC(cpu_exec), .CPU_OPCODE(opcode), .EXTERNAL_RESET_PIN_N(pin_n),
    .PORT0_WAKE_IRQS(p0), .PORT0_WAKE_EN(p0_en), .IRQ_PENDING(irq), .CPU_CLK_EN(cpu_clk_en),
    .PERIPH_CLK_EN(periph_clk_en), .OSC_EN(osc_en), .CLK_SEL(clk_sel),
    .CTRL_RST_N(ctrl_rst_n), .REGFILE_HOLD(regfile_hold), .PORT_HOLD(port_hold),
    .CPU_START(cpu_start), .START_ADDR(start_addr), .WAKE_SERVICE(wake));
  pdc_cpu_model i_cpu (.clk(clk), .wake_service(wake), .ctrl_rst_n(ctrl_rst_n),
    .cpu_exec(cpu_exec), .cpu_opcode(opcode), .irq_pending(irq));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task tally_and_finish();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    compares++;
    if (g !== x) begin
      fails++;
      $display("mismatch %s expected %0h seen %0h", nm, x, g);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
      if (k > 50) begin
        fails++;
        tally_and_finish();
      end
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // s=0 waits for the service pulse, s=1 for the start pulse
  task wt(input int s, input int lim);
    n = 0;
    while ((s ? cpu_start : wake) !== 1'b1) begin
      @(posedge clk);
      n++;
      if (n > lim) begin
        fails++;
        tally_and_finish();
      end
    end
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    wt(1, 5000);
    chk("start_addr", 32'h0100, start_addr);
    chk("clk_sel", 0, clk_sel);
    apb(0, OFS_STAB_COUNT, 0);
    chk("stab_rst", 32'hff, q);
    apb(0, 12'h020, 0);
    chk("slverr", 1, e);
    r = lfsr(r);
    exp_sel = r[4:3];
    apb(1, OFS_CLOCK_SELECT, {24'h0, r & 8'h18});
    apb(1, OFS_STAB_COUNT, 0);
    i_cpu.exec(OP_STOP);
    chk("unarmed", 1, osc_en);
    // wake by interrupt, by port 0 pin, then entry through the oscillator register
    for (int m = 0; m < 3; m++) begin
      r = lfsr(r);
      if (m == 2) apb(1, OFS_OSC_CONTROL, 32'h4);
      else begin
        apb(1, OFS_STOP_ENABLE, 1);
        i_cpu.exec(OP_STOP);
      end
      chk("osc_en", 0, osc_en);
      chk("hold", 1, regfile_hold);
      if (m == 1) begin
        p0_en <= 8'hff;
        p0 <= p0 ^ (8'h01 << r[2:0]);
      end
      else i_cpu.irq();
      wt(0, 60);
      if (m == 0) chk("stab_wait", 1, n >= 16 && n <= 21);
      chk("sel_kept", exp_sel, clk_sel);
      chk("cpu_clk", 1, cpu_clk_en);
      apb(0, OFS_STOP_ENABLE, 0);
      chk("arm_clr", 0, q);
    end
    i_cpu.exec(OP_IDLE);
    chk("port_hold", 1, port_hold);
    chk("periph", 1, periph_clk_en);
    chk("cpu_idle", 0, cpu_clk_en);
    i_cpu.irq();
    wt(0, 10);
    chk("sel_idle", exp_sel, clk_sel);
    i_cpu.exec(OP_IDLE);
    pin_n <= 1'b0;
    repeat (8) @(posedge clk);
    chk("sel_rst", 0, clk_sel);
    pin_n <= 1'b1;
    wt(1, 5000);
    apb(0, OFS_CLOCK_SELECT, 0);
    chk("sel_reg", 0, q);
    // pin reset and interrupt reach the idle controller at the same edge
    i_cpu.exec(OP_IDLE);
    pin_n <= 1'b0;
    repeat (2) @(posedge clk);
    i_cpu.irq();
    repeat (3) begin
      @(posedge clk);
      chk("pin_no_wake", 0, wake);
    end
    pin_n <= 1'b1;
    wt(1, 5000);
    apb(0, OFS_STATUS, 0);
    chk("pin_first", 2, q[ST_WAKE_RST_BIT:ST_WAKE_IRQ_BIT]);
    i_cpu.exec(OP_IDLE);
    i_cpu.irq();
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    chk("no_wake", 0, wake);
    rst_n <= 1'b1;
    wt(1, 5000);
    apb(0, OFS_STATUS, 0);
    chk("by_reset", 1, q[ST_WAKE_RST_BIT]);
    tally_and_finish();
  end
endmodule
